/* inc/sacx_pkg.sv */
// shared types, constants and helpers for the step attenuator control
package sacx_pkg;

  // serial word length and bit-count arithmetic
  localparam int SACX_WORD_W = 6;
  localparam logic [2:0] SACX_BITS_PER_WORD = 3'h6;

  // attenuation word, first shifted bit on top, weights in dB
  typedef struct packed {
    logic sixteen_db_bit;
    logic eight_db_bit;
    logic four_db_bit;
    logic two_db_bit;
    logic one_db_bit;
    logic half_db_bit;
  } sacx_word_t;

  // register byte addresses
  localparam logic [7:0] SACX_ADR_ATTEN = 8'h00;
  localparam logic [7:0] SACX_ADR_STATUS = 8'h04;
  localparam logic [7:0] SACX_ADR_CTRL = 8'h08;

  // field positions
  localparam int SACX_STS_LEN_ERR = 0;
  localparam int SACX_STS_STRAP_DONE = 1;
  localparam int SACX_STS_CNT_LSB = 8;
  localparam int SACX_CTRL_SER_EN = 0;

  // reset values
  localparam logic [5:0] SACX_WORD_RST = 6'h00;
  localparam logic SACX_SER_EN_RST = 1'b1;
  localparam logic [2:0] SACX_CNT_RST = 3'h0;

  // start-up sequence, gray coded along the path
  typedef enum logic [1:0] {
    SACX_ST_WAIT0 = 2'b00,
    SACX_ST_WAIT1 = 2'b01,
    SACX_ST_WAIT2 = 2'b11,
    SACX_ST_RUN = 2'b10
  } sacx_state_t;

  // classic wishbone request and response
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } sacx_wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } sacx_wb_rsp_t;

  // link-domain state
  typedef struct packed {
    logic [5:0] shift;
    logic [2:0] cnt_gray;
  } sacx_lnk_st_t;

  // system-domain state
  typedef struct packed {
    logic le_s1;
    logic le_s2;
    logic le_d;
    logic [5:0] par_s1;
    logic [5:0] par_s2;
    logic [2:0] cnt_s1;
    logic [2:0] cnt_s2;
    logic [2:0] cnt_last;
    sacx_word_t word;
    logic len_err;
    logic ser_en;
    sacx_state_t state;
    logic ack;
    logic [31:0] rdat;
  } sacx_ref_st_t;

  // gray conversions for the bit counter crossing
  function automatic logic [2:0] sacx_bin2gray(input logic [2:0] b);
    sacx_bin2gray = b ^ {1'b0, b[2:1]};
  endfunction

  function automatic logic [2:0] sacx_gray2bin(input logic [2:0] g);
    logic [2:0] b;
    b[2] = g[2];
    b[1] = g[1] ^ b[2];
    b[0] = g[0] ^ b[1];
    sacx_gray2bin = b;
  endfunction

endpackage

/* src/sacx_top.sv */
// serial control logic of a six-bit step attenuator with wishbone access
//
// Local design decisions: register access over Wishbone and the address map.
module sacx_top
  import sacx_pkg::*;
(
  // system clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // register bus
  input wire sacx_wb_req_t wb_req,
  output sacx_wb_rsp_t wb_rsp,
  // serial link
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic load_strobe,
  // power-up straps
  input wire sacx_word_t par_data,
  // attenuation control bits
  output sacx_word_t atten
);

  sacx_lnk_st_t l_r;
  sacx_lnk_st_t l_nxt;
  sacx_ref_st_t r_r;
  sacx_ref_st_t r_nxt;
  logic [2:0] cnt_now;
  logic [2:0] cnt_diff;
  logic load_evt;
  logic bus_wr;
  logic [7:0] wdat;

  // link side: shift on the serial clock rising edge
  always_comb begin
    l_nxt = l_r;
    l_nxt.shift = {l_r.shift[4:0], ser_data};
    // bit counter, gray coded so the system side can read it safely
    l_nxt.cnt_gray = sacx_bin2gray(sacx_gray2bin(l_r.cnt_gray) + 3'h1);
  end

  always_ff @(posedge ser_clk or negedge rst_b) begin
    if (!rst_b) begin
      l_r <= '{shift: SACX_WORD_RST, cnt_gray: SACX_CNT_RST};
    end else begin
      l_r <= l_nxt;
    end
  end

  // helpers for load and bus
  always_comb begin
    cnt_now = sacx_gray2bin(r_r.cnt_s2);
    cnt_diff = cnt_now - r_r.cnt_last;
    load_evt = r_r.le_s2 & ~r_r.le_d & r_r.ser_en &
               (r_r.state == SACX_ST_RUN);
    bus_wr = r_r.ack & wb_req.cyc & wb_req.stb & wb_req.we &
             wb_req.sel[0];
    wdat = wb_req.dat[7:0];
  end

  // system side next state
  always_comb begin
    r_nxt = r_r;
    // two-flop synchronisers for pins and the link counter
    r_nxt.le_s1 = load_strobe;
    r_nxt.le_s2 = r_r.le_s1;
    r_nxt.le_d = r_r.le_s2;
    r_nxt.par_s1 = par_data;
    r_nxt.par_s2 = r_r.par_s1;
    r_nxt.cnt_s1 = l_r.cnt_gray;
    r_nxt.cnt_s2 = r_r.cnt_s1;

    // start-up: wait for the strap synchroniser, then load
    case (r_r.state)
      SACX_ST_WAIT0: begin
        r_nxt.state = SACX_ST_WAIT1;
      end
      SACX_ST_WAIT1: begin
        r_nxt.state = SACX_ST_WAIT2;
      end
      SACX_ST_WAIT2: begin
        r_nxt.word = sacx_word_t'(r_r.par_s2);
        r_nxt.state = SACX_ST_RUN;
      end
      SACX_ST_RUN: begin
        r_nxt.state = SACX_ST_RUN;
      end
      default: begin
        r_nxt.state = SACX_ST_WAIT0;
      end
    endcase

    // register writes, taken at the edge that ends the ack cycle
    if (bus_wr) begin
      case (wb_req.adr)
        SACX_ADR_ATTEN: begin
          r_nxt.word = sacx_word_t'(wdat[5:0]);
        end
        SACX_ADR_STATUS: begin
          if (wdat[SACX_STS_LEN_ERR]) begin
            r_nxt.len_err = 1'b0;
          end
        end
        SACX_ADR_CTRL: begin
          r_nxt.ser_en = wdat[SACX_CTRL_SER_EN];
        end
        default: begin
          r_nxt.ser_en = r_r.ser_en;
        end
      endcase
    end

    // serial load; placed after bus writes so it wins
    if (load_evt) begin
      // word is the sum of weights
      r_nxt.word = sacx_word_t'(l_r.shift);
      r_nxt.cnt_last = cnt_now;
      // flag words whose bit count, modulo eight, is not six
      if (cnt_diff != SACX_BITS_PER_WORD) begin
        r_nxt.len_err = 1'b1;
      end
    end

    // one-cycle ack per request, read data alongside
    r_nxt.ack = wb_req.cyc & wb_req.stb & ~r_r.ack;
    r_nxt.rdat = '0;
    if (wb_req.cyc & wb_req.stb & ~r_r.ack & ~wb_req.we) begin
      case (wb_req.adr)
        SACX_ADR_ATTEN: begin
          r_nxt.rdat[5:0] = r_r.word;
        end
        SACX_ADR_STATUS: begin
          r_nxt.rdat[SACX_STS_LEN_ERR] = r_r.len_err;
          r_nxt.rdat[SACX_STS_STRAP_DONE] = (r_r.state == SACX_ST_RUN);
          r_nxt.rdat[SACX_STS_CNT_LSB +: 3] = cnt_now;
        end
        SACX_ADR_CTRL: begin
          r_nxt.rdat[SACX_CTRL_SER_EN] = r_r.ser_en;
        end
        default: begin
          r_nxt.rdat = '0;
        end
      endcase
    end
  end

  // system side registers
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      r_r <= '{le_s1: 1'b0, le_s2: 1'b0, le_d: 1'b0,
               par_s1: SACX_WORD_RST, par_s2: SACX_WORD_RST,
               cnt_s1: SACX_CNT_RST, cnt_s2: SACX_CNT_RST,
               cnt_last: SACX_CNT_RST, word: SACX_WORD_RST,
               len_err: 1'b0, ser_en: SACX_SER_EN_RST,
               state: SACX_ST_WAIT0, ack: 1'b0, rdat: 32'h0};
    end else begin
      r_r <= r_nxt;
    end
  end

  // outputs straight from flops
  assign wb_rsp = '{ack: r_r.ack, dat: r_r.rdat};
  assign atten = r_r.word;

endmodule

/* bench/sacx_chk.sv */
// port checker of the attenuator control
module sacx_chk
  import sacx_pkg::*;
(
  // system side
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire sacx_wb_req_t wb_req,
  input wire sacx_wb_rsp_t wb_rsp,
  // link side
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic load_strobe,
  input wire sacx_word_t par_data,
  input wire sacx_word_t atten
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  logic [5:0] sh;
  // bits seen on the link, first one on top
  always_ff @(posedge ser_clk) sh <= {sh[4:0], ser_data};
  a_ack_late: assert property (wb_req.cyc && wb_req.stb && !wb_rsp.ack
    |=> wb_rsp.ack) else $error("ack late");
  a_ack_once: assert property (wb_rsp.ack |=> !wb_rsp.ack)
    else $error("ack held");
  a_dat_idle: assert property (!wb_rsp.ack |-> wb_rsp.dat == 0)
    else $error("dat not idle");
  a_strap_load: assert property (
    disable iff (1'b0) !rst_b ##1 rst_b [*4] |-> atten == par_data)
    else $error("strap lost");
  a_atten_cause: assert property ($changed(atten) |-> $past(wb_rsp.ack)
    || $past(load_strobe, 3) || !$past(rst_b, 4)) else $error("stray");
  a_word_order: assert property (
    $changed(atten) && $past(load_strobe, 3) && !$past(wb_rsp.ack)
    |-> atten == sh) else $error("word order");
endmodule
bind sacx_top sacx_chk u_chk (.ref_clk(ref_clk), .rst_b(rst_b),
  .wb_req(wb_req), .wb_rsp(wb_rsp), .ser_clk(ser_clk),
  .ser_data(ser_data), .load_strobe(load_strobe),
  .par_data(par_data), .atten(atten));

/* bench/sacx_ctl_model.sv */
// behavioural controller on the serial link
module sacx_ctl_model (
  // serial link
  output logic ser_clk,
  output logic ser_data,
  output logic load_strobe
);
  timeunit 1ns;
  timeprecision 1ps;
  initial ser_clk = 1'b0;
  initial ser_data = 1'b0;
  initial load_strobe = 1'b0;
  // shift n bits, first bit on top, then pulse the strobe
  // serial clock pace, 32 ns high and 32 ns low
  task automatic send(input logic [7:0] w, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      // data set before rise, held past fall
      ser_data = w[i];
      #16 ser_clk = 1'b1;
      #32 ser_clk = 1'b0;
      #16 ser_data = ~w[i];
    end
    load_strobe = 1'b1;
    #40 load_strobe = 1'b0;
  endtask
endmodule

/* bench/step_attenuator_serial_control_bench.sv */
// self-checking bench of the attenuator control
module step_attenuator_serial_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import sacx_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  sacx_wb_req_t wb_req = '0;
  sacx_wb_rsp_t wb_rsp;
  sacx_word_t par_data = '0;
  sacx_word_t atten;
  logic ser_clk, ser_data, load_strobe;
  logic [31:0] q;
  int n_fail = 0;
  int checked = 0;
  always #2.5 ref_clk = ~ref_clk;
  sacx_top dut (.ref_clk(ref_clk), .rst_b(rst_b), .wb_req(wb_req),
    .wb_rsp(wb_rsp), .ser_clk(ser_clk), .ser_data(ser_data),
    .load_strobe(load_strobe), .par_data(par_data), .atten(atten));
  sacx_ctl_model m (.ser_clk(ser_clk), .ser_data(ser_data),
    .load_strobe(load_strobe));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      n_fail++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic complete_run;
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // one classic bus cycle, bounded wait for ack
  task automatic wb(input logic we, input logic [7:0] a,
    input logic [31:0] d);
    int k;
    k = 0;
    wb_req <= '{1'b1, 1'b1, we, a, 4'hF, d};
    do begin
      @(posedge ref_clk);
      k++;
    end while (wb_rsp.ack !== 1'b1 && k < 20);
    q = wb_rsp.dat;
    wb_req <= '0;
    if (wb_rsp.ack !== 1'b1) begin
      chk(32'h0, 32'h1);
      complete_run;
    end
    @(posedge ref_clk);
  endtask
  // restart with a strapped word
  task automatic t_strap(input logic [5:0] v);
    par_data <= v;
    rst_b <= 1'b0;
    repeat (12) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (5) @(posedge ref_clk);
    chk(atten, v);
  endtask
  // walk a single set bit through every weight
  task automatic t_serial;
    for (int i = 0; i < 6; i++) begin
      m.send(8'h20 >> i, 6);
      repeat (4) @(posedge ref_clk);
      chk(atten, 6'h20 >> i);
    end
  endtask
  // direct write, unmapped place, strobes switched off
  task automatic t_regs;
    wb(1'b1, SACX_ADR_ATTEN, 32'h15);
    wb(1'b1, 8'h0C, 32'h3F);
    wb(1'b0, 8'h0C, 32'h0);
    chk(q, 32'h0);
    wb(1'b0, SACX_ADR_ATTEN, 32'h0);
    chk(q, 32'h15);
    wb(1'b1, SACX_ADR_CTRL, 32'h0);
    m.send(8'h2A, 6);
    repeat (4) @(posedge ref_clk);
    chk(atten, 6'h15);
    wb(1'b1, SACX_ADR_CTRL, 32'h1);
    wb(1'b0, SACX_ADR_CTRL, 32'h0);
    chk(q, 32'h1);
  endtask
  // a seven-bit word loads its tail and flags the length
  task automatic t_length;
    m.send(8'h4B, 7);
    repeat (4) @(posedge ref_clk);
    chk(atten, 6'h0B);
    wb(1'b0, SACX_ADR_STATUS, 32'h0);
    chk(q & 32'h3, 32'h3);
    wb(1'b1, SACX_ADR_STATUS, 32'h1);
    wb(1'b0, SACX_ADR_STATUS, 32'h0);
    chk(q & 32'h3, 32'h2);
    chk(q, 32'h102);
  endtask
  // main sequence
  initial begin
    for (int v = 0; v < 64; v++) t_strap(6'(v));
    t_serial;
    t_regs;
    t_length;
    complete_run;
  end
endmodule
